/* File: design/state_store_and_srq_mask.sv */
// state save/recall store and service request enable mask
`timescale 1ns/1ps
module state_store_and_srq_mask
  import state_store_pkg::*;
#(
  parameter int                 STATE_W      = 32,  // operating state width
  parameter logic [STATE_W-1:0] PRESET_STATE = '0   // preset default state
) (
  // clock and reset
  input  wire logic                          REF_CLK,
  input  wire logic                          RESET_N,
  // command port
  input  wire logic                          CMD_VALID,
  input  wire logic [state_store_pkg::OP_W-1:0]  CMD_OPCODE,
  input  wire logic [state_store_pkg::ARG_W-1:0] CMD_ARG,
  output logic                               CMD_DONE,
  output logic                               CMD_ERROR,
  output logic                               QUERY_VALID,
  output logic [7:0]                         QUERY_DATA,
  // operating state
  input  wire logic                          STATE_WR,
  input  wire logic [STATE_W-1:0]            STATE_WDATA,
  input  wire logic                          PANEL_PRESET,
  output logic [STATE_W-1:0]                 OPER_STATE,
  // status byte and summary
  input  wire logic [7:0]                    STATUS_BYTE,
  output logic [7:0]                         SERVICE_REQUEST_MASK,
  output logic                               SUMMARY_STATUS
);
  import state_store_pkg::*;

  // ****************************************************************
  // storage and decode
  // ****************************************************************
  logic [STATE_W-1:0]    slot_mem [SLOT_COUNT];  // saved states
  logic [SLOT_COUNT-1:0] slot_full;              // slot ever written
  logic [7:0]            mask;                   // service request mask
  logic [SLOT_IDX_W-1:0] idx;                    // slot index from arg
  logic                  slot_ok;                // arg names a slot
  logic                  mask_ok;                // arg fits the mask
  logic                  do_save;                // accepted save
  logic                  do_recall;              // accepted recall
  logic                  do_preset;              // reset cmd or panel key
  logic                  do_mask_wr;             // accepted mask write
  logic                  do_query;               // mask query
  logic                  bad_cmd;                // rejected command
  logic [STATE_W-1:0]    rd_word;                // slot being recalled

  assign idx     = CMD_ARG[SLOT_IDX_W-1:0];
  assign slot_ok = (CMD_ARG <= SLOT_MAX);
  assign mask_ok = (CMD_ARG <= MASK_MAX);
  assign rd_word = slot_ok ? slot_mem[idx] : PRESET_STATE;

  // command decode, argument range checked before any effect
  always_comb begin
    do_save    = 1'b0;
    do_recall  = 1'b0;
    do_mask_wr = 1'b0;
    do_query   = 1'b0;
    bad_cmd    = 1'b0;
    do_preset  = PANEL_PRESET;
    if (CMD_VALID) begin
      case (CMD_OPCODE)
        OP_SAVE:       if (slot_ok) do_save = 1'b1;
                       else bad_cmd = 1'b1;
        OP_RECALL:     if (slot_ok) do_recall = 1'b1;
                       else bad_cmd = 1'b1;
        OP_RESET:      do_preset = 1'b1;
        OP_MASK_WRITE: if (mask_ok) do_mask_wr = 1'b1;
                       else bad_cmd = 1'b1;
        OP_MASK_QUERY: do_query = 1'b1;
        // unknown code refused
        default:       bad_cmd = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // save slots
  // ****************************************************************
  // slot contents need no reset, only the full flags do
  // store current state
  always_ff @(posedge REF_CLK) begin
    if (do_save) begin
      slot_mem[idx] <= OPER_STATE;
    end
  end

  // full flags, cleared at reset so every slot starts empty
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      slot_full <= '0;
    end else if (do_save) begin
      slot_full[idx] <= 1'b1;
    end
  end

  // ****************************************************************
  // operating state
  // ****************************************************************
  // commands win over a local write landing in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      OPER_STATE <= PRESET_STATE;
    end else if (do_preset) begin
      OPER_STATE <= PRESET_STATE;
    end else if (do_recall) begin
      OPER_STATE <= slot_full[idx] ? rd_word : PRESET_STATE;
    end else if (STATE_WR) begin
      // ordinary change from the instrument
      OPER_STATE <= STATE_WDATA;
    end
  end

  // ****************************************************************
  // service request mask and summary
  // ****************************************************************
  // mask register, written whole, bits 2..0 kept as written
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      mask <= MASK_RESET;
    end else if (do_mask_wr) begin
      mask <= CMD_ARG[7:0];
    end
  end
  assign SERVICE_REQUEST_MASK = mask;

  // summary over enabled sources; bit 6 excluded to avoid feedback
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      SUMMARY_STATUS <= 1'b0;
    end else begin
      SUMMARY_STATUS <= |(STATUS_BYTE & mask & MSS_SOURCES);
    end
  end

  // ****************************************************************
  // answers
  // ****************************************************************
  // done and error are one-cycle pulses after the taking edge
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      CMD_DONE    <= 1'b0;
      CMD_ERROR   <= 1'b0;
      QUERY_VALID <= 1'b0;
    end else begin
      CMD_DONE    <= CMD_VALID;
      CMD_ERROR   <= bad_cmd;
      QUERY_VALID <= do_query;
    end
  end

  // query data holds until the next query
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      QUERY_DATA <= MASK_RESET;
    end else if (do_query) begin
      QUERY_DATA <= mask;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_recall_full;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (CMD_VALID && CMD_OPCODE == OP_RECALL && slot_ok && slot_full[idx]
     && !PANEL_PRESET) |=> (OPER_STATE == $past(rd_word));
  endproperty
  a_recall_full: assert property (p_recall_full)
    else $error("recall did not load slot contents");

  property p_recall_empty;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (CMD_VALID && CMD_OPCODE == OP_RECALL && slot_ok && !slot_full[idx])
    |=> (OPER_STATE == PRESET_STATE);
  endproperty
  a_recall_empty: assert property (p_recall_empty)
    else $error("empty slot recall did not load preset");

  property p_reset_cmd;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (CMD_VALID && CMD_OPCODE == OP_RESET)
    |=> (OPER_STATE == PRESET_STATE) && CMD_DONE && !CMD_ERROR;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command did not load preset");

  property p_save;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (CMD_VALID && CMD_OPCODE == OP_SAVE && slot_ok)
    |=> slot_full[$past(idx)] && (slot_mem[$past(idx)] == $past(OPER_STATE));
  endproperty
  a_save: assert property (p_save)
    else $error("save did not store current state");

  property p_mask_write;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (CMD_VALID && CMD_OPCODE == OP_MASK_WRITE && mask_ok)
    |=> (SERVICE_REQUEST_MASK == $past(CMD_ARG[7:0])) && !CMD_ERROR;
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_enable_bit;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (STATUS_BYTE[BIT_ESB] && mask[BIT_ESB]) |=> SUMMARY_STATUS;
  endproperty
  a_enable_bit: assert property (p_enable_bit)
    else $error("enabled status bit did not raise summary");

  property p_unused_bits;
    @(posedge REF_CLK) disable iff (!RESET_N)
    ((STATUS_BYTE & mask & MSS_SOURCES) == 8'h00) |=> !SUMMARY_STATUS;
  endproperty
  a_unused_bits: assert property (p_unused_bits)
    else $error("disabled or unused bit raised summary");

  property p_query;
    @(posedge REF_CLK) disable iff (!RESET_N)
    // second cycle: the pulse may only stand again for a back-to-back query
    (CMD_VALID && CMD_OPCODE == OP_MASK_QUERY) |=> (QUERY_VALID
    && (QUERY_DATA == $past(mask)) && (mask == $past(mask)))
    ##1 (!QUERY_VALID || $past(do_query));
  endproperty
  a_query: assert property (p_query)
    else $error("mask query answer wrong");

  property p_reject;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (CMD_VALID && CMD_OPCODE == OP_MASK_WRITE && !mask_ok)
    |=> CMD_ERROR && $stable(mask);
  endproperty
  a_reject: assert property (p_reject)
    else $error("out-of-range mask not refused");

endmodule

/* File: design/state_store_pkg.sv */
// constants and command codes for the state store and service mask block
// ****************************************************************
// Summary of operation
// - recall loads whole state from slot 0-9
// - recall of empty slot loads preset state
// - reset command equals front-panel preset action
// - save copies whole current state into slot
// - mask write accepts values 0 through 255
// - mask one enables status bit, zero blocks
// - mask query returns mask, read leaves it
// - mask bits 7,5,4,3 map status summaries, bit 6 feeds nothing
// - mask bits 2,1,0 enable nothing
// - summary set when enabled status bit 7,5,4 or 3 set
// ****************************************************************
package state_store_pkg;

  // ****************************************************************
  // command port
  // ****************************************************************
  localparam int OP_W  = 3;                 // command code width
  localparam int ARG_W = 16;                // argument width, wide on purpose
  // command codes
  localparam logic [OP_W-1:0] OP_SAVE       = 3'h1;
  localparam logic [OP_W-1:0] OP_RECALL     = 3'h2;
  localparam logic [OP_W-1:0] OP_RESET      = 3'h3;
  localparam logic [OP_W-1:0] OP_MASK_WRITE = 3'h4;
  localparam logic [OP_W-1:0] OP_MASK_QUERY = 3'h5;

  // ****************************************************************
  // slots and mask
  // ****************************************************************
  localparam int SLOT_COUNT = 10;            // slots 0 to 9
  localparam int SLOT_IDX_W = 4;             // bits to index a slot
  localparam logic [ARG_W-1:0] SLOT_MAX = 16'h0009;  // highest slot
  localparam logic [ARG_W-1:0] MASK_MAX = 16'h00FF;  // highest mask value
  localparam logic [7:0] MASK_RESET     = 8'h00;     // mask after reset
  // status bits that may feed the summary: 7,5,4,3; bit 6 is the
  // summary itself and bits 2..0 are unused
  localparam logic [7:0] MSS_SOURCES    = 8'hB8;
  localparam int BIT_OPER = 7;               // operation summary
  localparam int BIT_RQS  = 6;               // request service
  localparam int BIT_ESB  = 5;               // event status summary
  localparam int BIT_MAV  = 4;               // message available
  localparam int BIT_QUES = 3;               // questionable summary

endpackage

/* File: dv/remote_controller_model.sv */
// model of the remote controller that issues common commands
`timescale 1ns/1ps
module remote_controller_model (
  // clock
  input  wire logic                              clk,
  // command port
  output logic                                   cmd_valid,
  output logic [state_store_pkg::OP_W-1:0]       cmd_opcode,
  output logic [state_store_pkg::ARG_W-1:0]      cmd_arg
);
  import state_store_pkg::*;
  // idle port at time zero
  initial begin
    cmd_valid  = 1'b0;
    cmd_opcode = '0;
    cmd_arg    = '0;
  end
  // one whole command
  // no ready exists, so the command is held for exactly one edge
  task automatic send(input logic [OP_W-1:0] op,
                      input logic [ARG_W-1:0] arg);
    @(negedge clk);
    cmd_valid  = 1'b1;
    cmd_opcode = op;
    cmd_arg    = arg;
    @(negedge clk);
    cmd_valid  = 1'b0;
    // released lines show the inverse, never the old value
    cmd_opcode = ~op;
    cmd_arg    = ~arg;
  endtask
endmodule

/* File: dv/state_store_and_srq_mask_tb.sv */
// self-checking bench for the state store and service mask block
`timescale 1ns/1ps
module state_store_and_srq_mask_tb;
  import state_store_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam logic [31:0] PRESET_VALUE = 32'hA5A5_0F0F;  // easy to spot
  typedef struct {
    logic [OP_W-1:0]  op;
    logic [ARG_W-1:0] arg;
    logic             err;
    logic             qv;
    logic [7:0]       mask;
  } row_s;
  logic              clk, reset_n, cmd_valid, done, err, qv, sum;
  logic              state_wr, panel_preset;
  logic [OP_W-1:0]   opcode;
  logic [ARG_W-1:0]  arg;
  logic [7:0]        qdata, mask, status_byte;
  logic [31:0]       state, wdata;
  int                fail_count = 0;
  int                check_count = 0;
  // ordinary commands: refused ones must leave mask and state alone
  row_s rows [12] = '{
    '{OP_MASK_WRITE, 16'h0020, 1'b0, 1'b0, 8'h20},
    '{OP_MASK_QUERY, 16'h0000, 1'b0, 1'b1, 8'h20},
    '{OP_MASK_QUERY, 16'h0000, 1'b0, 1'b1, 8'h20},
    '{OP_MASK_WRITE, 16'h0100, 1'b1, 1'b0, 8'h20},
    '{OP_MASK_WRITE, 16'h00FF, 1'b0, 1'b0, 8'hFF},
    '{OP_MASK_QUERY, 16'h0000, 1'b0, 1'b1, 8'hFF},
    '{OP_MASK_WRITE, 16'h0000, 1'b0, 1'b0, 8'h00},
    '{3'h0,          16'h0000, 1'b1, 1'b0, 8'h00},
    '{3'h7,          16'h0000, 1'b1, 1'b0, 8'h00},
    '{OP_SAVE,       16'h000A, 1'b1, 1'b0, 8'h00},
    '{OP_RECALL,     16'hFFFF, 1'b1, 1'b0, 8'h00},
    '{OP_MASK_QUERY, 16'h0000, 1'b0, 1'b1, 8'h00}};
  remote_controller_model u_ctl (.clk(clk), .cmd_valid(cmd_valid),
    .cmd_opcode(opcode), .cmd_arg(arg));
  state_store_and_srq_mask #(.STATE_W(32), .PRESET_STATE(PRESET_VALUE))
    u_dut (.REF_CLK(clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(opcode), .CMD_ARG(arg), .CMD_DONE(done), .CMD_ERROR(err),
    .QUERY_VALID(qv), .QUERY_DATA(qdata), .STATE_WR(state_wr),
    .STATE_WDATA(wdata), .PANEL_PRESET(panel_preset), .OPER_STATE(state),
    .STATUS_BYTE(status_byte), .SERVICE_REQUEST_MASK(mask),
    .SUMMARY_STATUS(sum));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one command, then look at the one-cycle answer pulses
  task automatic run(input logic [OP_W-1:0] op, input logic [ARG_W-1:0] a);
    // send returns on the negedge inside the pulse cycle, so look now
    u_ctl.send(op, a);
    check("done", done, 1'b1);
  endtask
  task automatic set_state(input logic [31:0] d);
    @(negedge clk);
    state_wr = 1'b1;
    wdata = d;
    @(negedge clk);
    state_wr = 1'b0;
    wdata = ~d;
  endtask
  // summary registers status and mask at one edge; the task waits two
  task automatic sum_case(input logic [15:0] m, input logic [7:0] st,
                          input logic e);
    run(OP_MASK_WRITE, m);
    status_byte = st;
    repeat (2) @(negedge clk);
    check("summary", sum, e);
    check("done idle", done, 1'b0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // clock, watchdog and sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run is well under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    {reset_n, state_wr, panel_preset, status_byte, wdata} = '0;
    repeat (10) @(negedge clk);
    check("rst mask", mask, 8'h00);
    check("rst state", state, PRESET_VALUE);
    reset_n = 1'b1;
    // non-preset state, so a refused recall that loads anything shows
    set_state(32'h2468_ACE0);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].arg);
      check("error", err, rows[i].err);
      check("qvalid", qv, rows[i].qv);
      check("mask", mask, rows[i].mask);
      if (rows[i].qv) check("qdata", qdata, rows[i].mask);
      check("state", state, 32'h2468_ACE0);
    end
    set_state(32'h1234_5678);
    run(OP_RECALL, 16'h0003);
    check("empty recall", state, PRESET_VALUE);
    for (int s = 0; s < 10; s++) begin
      set_state(32'h5100_0000 + s);
      run(OP_SAVE, s[ARG_W-1:0]);
    end
    set_state(32'h0BAD_0009);
    run(OP_SAVE, 16'h0009);
    set_state(32'h0000_0000);
    for (int s = 9; s >= 0; s--) begin
      run(OP_RECALL, s[ARG_W-1:0]);
      check("recall", state,
            s == 9 ? 32'h0BAD_0009 : 32'h5100_0000 + s);
    end
    run(OP_RESET, 16'h0000);
    check("reset cmd", state, PRESET_VALUE);
    set_state(32'h7777_0000);
    @(negedge clk);
    panel_preset = 1'b1;
    @(negedge clk);
    panel_preset = 1'b0;
    check("panel", state, PRESET_VALUE);
    for (int b = 0; b < 8; b++) begin
      sum_case(16'h0001 << b, 8'h01 << b, b >= 3 && b != 6);
    end
    sum_case(16'h00F7, 8'h08, 1'b0);
    sum_case(16'h00FF, 8'h47, 1'b0);
    set_state(32'h0F0F_5555);
    // second reset mid-run empties every slot again
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check("rst2 mask", mask, 8'h00);
    check("rst2 state", state, PRESET_VALUE);
    // move off preset first, else a recall that loads nothing would go unseen
    set_state(32'h3C3C_0000);
    run(OP_RECALL, 16'h0009);
    check("rst2 recall", state, PRESET_VALUE);
    tally_and_finish;
  end
endmodule
